// >>> rtl/carrier_keying_logic.sv
// Carrier keying logic with APB jumper and status registers.
`timescale 1ns/100ps
`default_nettype none
module carrier_keying_logic (
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Relay command lines
  input  wire logic        start_line_i,
  input  wire logic        stop_line_i,
  input  wire logic        low_level_test_line_i,
  input  wire logic        high_checkback_i,
  input  wire logic        low_checkback_i,
  input  wire logic        voice_request_i,
  input  wire logic        relay_terminal_line_high_i,
  input  wire logic        relay_terminal_line_low_i,
  // Front panel buttons
  input  wire logic        high_test_button_i,
  input  wire logic        low_test_button_i,
  // Transmitter keys
  output logic             high_level_key_o,
  output logic             voice_key_o,
  output logic             any_key_o,
  // Indicator lamps
  output logic             high_level_lamp_o,
  output logic             low_level_lamp_o,
  output logic             voice_lamp_o
);

  // ==========================================================================
  // Reset release
  logic rst_meta_r;
  logic rst_sync_n;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_n <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Pin synchronisers
  // Relay contacts bounce and the buttons are mechanical; every line is
  // resampled on the local clock before any keying decision looks at it.
  pin_sync_if sif ();

  always_comb begin
    sif.raw                            = '0;
    sif.raw[keying_pkg::PIN_START]     = start_line_i;
    sif.raw[keying_pkg::PIN_STOP]      = stop_line_i;
    sif.raw[keying_pkg::PIN_LOW_TEST]  = low_level_test_line_i;
    sif.raw[keying_pkg::PIN_HIGH_CB]   = high_checkback_i;
    sif.raw[keying_pkg::PIN_LOW_CB]    = low_checkback_i;
    sif.raw[keying_pkg::PIN_VOICE]     = voice_request_i;
    sif.raw[keying_pkg::PIN_HIGH_BTN]  = high_test_button_i;
    sif.raw[keying_pkg::PIN_LOW_BTN]   = low_test_button_i;
    sif.raw[keying_pkg::PIN_TERM_HIGH] = relay_terminal_line_high_i;
    sif.raw[keying_pkg::PIN_TERM_LOW]  = relay_terminal_line_low_i;
  end

  pin_sync u_pin_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_sync_n),
    .sif       (sif.sync_mp)
  );

  logic start_s;
  logic stop_s;
  logic low_test_s;
  logic high_cb_s;
  logic low_cb_s;
  logic voice_s;
  logic high_btn_s;
  logic low_btn_s;
  logic term_high_s;
  logic term_low_s;

  assign start_s     = sif.sync[keying_pkg::PIN_START];
  assign stop_s      = sif.sync[keying_pkg::PIN_STOP];
  assign low_test_s  = sif.sync[keying_pkg::PIN_LOW_TEST];
  assign high_cb_s   = sif.sync[keying_pkg::PIN_HIGH_CB];
  assign low_cb_s    = sif.sync[keying_pkg::PIN_LOW_CB];
  assign voice_s     = sif.sync[keying_pkg::PIN_VOICE];
  assign high_btn_s  = sif.sync[keying_pkg::PIN_HIGH_BTN];
  assign low_btn_s   = sif.sync[keying_pkg::PIN_LOW_BTN];
  assign term_high_s = sif.sync[keying_pkg::PIN_TERM_HIGH];
  assign term_low_s  = sif.sync[keying_pkg::PIN_TERM_LOW];

  // ==========================================================================
  // Jumper register
  logic [keying_pkg::CFG_W-1:0] cfg_r;
  logic                         start_inv;
  logic                         stop_inv;
  logic                         low_inv;
  logic                         stop_prio;
  logic                         tristate;

  assign start_inv = cfg_r[keying_pkg::CFG_START_INV];
  assign stop_inv  = cfg_r[keying_pkg::CFG_STOP_INV];
  assign low_inv   = cfg_r[keying_pkg::CFG_LOW_INV];
  assign stop_prio = cfg_r[keying_pkg::CFG_STOP_PRIO];
  assign tristate  = cfg_r[keying_pkg::CFG_TRISTATE];

  // ==========================================================================
  // Keying decisions
  logic start_res;
  logic stop_res;
  logic low_req;
  logic high_req;
  logic high_key_nxt;
  logic low_key_nxt;
  logic voice_key_nxt;
  logic any_key_nxt;

  always_comb begin
    if (tristate) begin
      // An open line drives neither terminal level and so stays idle.
      start_res = term_high_s & ~term_low_s;
      stop_res  = term_low_s & ~term_high_s;
    end else begin
      start_res = start_s ^ start_inv;
      stop_res  = stop_s ^ stop_inv;
    end
  end

  assign low_req       = (low_test_s ^ low_inv) | low_btn_s | low_cb_s;
  assign high_req      = start_res | high_btn_s | high_cb_s;
  assign high_key_nxt  = high_req & ~(stop_prio & stop_res);
  assign low_key_nxt   = low_req;
  assign voice_key_nxt = voice_s & ~stop_res & ~high_key_nxt & ~low_key_nxt;
  assign any_key_nxt   = high_key_nxt | low_key_nxt | voice_key_nxt;

  // ==========================================================================
  // Key and lamp flip-flops
  logic high_key_r;
  logic low_key_r;
  logic voice_key_r;
  logic any_key_r;
  logic start_res_r;
  logic stop_res_r;

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      high_key_r  <= 1'b0;
      low_key_r   <= 1'b0;
      voice_key_r <= 1'b0;
      any_key_r   <= 1'b0;
      start_res_r <= 1'b0;
      stop_res_r  <= 1'b0;
    end else begin
      high_key_r  <= high_key_nxt;
      low_key_r   <= low_key_nxt;
      voice_key_r <= voice_key_nxt;
      any_key_r   <= any_key_nxt;
      start_res_r <= start_res;
      stop_res_r  <= stop_res;
    end
  end

  assign high_level_key_o  = high_key_r;
  assign voice_key_o       = voice_key_r;
  assign any_key_o         = any_key_r;
  assign high_level_lamp_o = high_key_r;
  assign low_level_lamp_o  = low_key_r;
  assign voice_lamp_o      = voice_key_r;

  // ==========================================================================
  // APB slave
  logic        setup_ph;
  logic        access_ph;
  logic        hit_cfg;
  logic        hit_stat;
  logic [31:0] stat_word;
  logic [31:0] prdata_r;

  assign setup_ph  = psel_i & ~penable_i;
  assign access_ph = psel_i & penable_i;
  assign hit_cfg   = (paddr_i == keying_pkg::CFG_OFFSET);
  assign hit_stat  = (paddr_i == keying_pkg::STATUS_OFFSET);
  assign pready_o  = 1'b1;
  assign pslverr_o = access_ph & ~hit_cfg & ~hit_stat;
  assign prdata_o  = prdata_r;

  always_comb begin
    stat_word                               = '0;
    stat_word[keying_pkg::STAT_PINS_POS +: keying_pkg::NUM_PINS] = sif.sync;
    stat_word[keying_pkg::STAT_HIGH_KEY]    = high_key_r;
    stat_word[keying_pkg::STAT_LOW_KEY]     = low_key_r;
    stat_word[keying_pkg::STAT_VOICE_KEY]   = voice_key_r;
    stat_word[keying_pkg::STAT_ANY_KEY]     = any_key_r;
    stat_word[keying_pkg::STAT_START]       = start_res_r;
    stat_word[keying_pkg::STAT_STOP]        = stop_res_r;
    stat_word[keying_pkg::STAT_CFG_POS +: keying_pkg::CFG_W] = cfg_r;
  end

  // Writes take effect only in the access phase; the lane of byte zero
  // carries every jumper bit, so the other strobes are ignored.
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_r <= keying_pkg::CFG_RST;
    end else if (access_ph && pwrite_i && hit_cfg && pstrb_i[0]) begin
      cfg_r <= pwdata_i[keying_pkg::CFG_W-1:0];
    end
  end

  // Read data is captured in the setup phase so it comes from a flip-flop
  // while pready stays high with no wait state.
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_i) begin
      if (hit_cfg) begin
        prdata_r <= {{(32 - keying_pkg::CFG_W){1'b0}}, cfg_r};
      end else if (hit_stat) begin
        prdata_r <= stat_word;
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_sync_n);

  property p_start_norm;
    !tristate && !start_inv && start_s && !stop_prio |=> high_key_r;
  endproperty
  a_start_norm: assert property (p_start_norm) else $error("normal start did not key");

  property p_start_inv;
    !tristate && start_inv && !start_s && !stop_prio |=> high_key_r;
  endproperty
  a_start_inv: assert property (p_start_inv) else $error("inverted start did not key");

  property p_start_high;
    start_res && !(stop_prio && stop_res) |=> high_key_r && any_key_r;
  endproperty
  a_start_high: assert property (p_start_high) else $error("start not at high level");

  property p_stop_sense;
    !tristate && (stop_s != stop_inv) && voice_s |=> !voice_key_r && stop_res_r;
  endproperty
  a_stop_sense: assert property (p_stop_sense) else $error("stop sense wrong");

  property p_low_sense;
    (low_test_s != low_inv) |=> low_key_r && low_level_lamp_o && any_key_r;
  endproperty
  a_low_sense: assert property (p_low_sense) else $error("low test sense wrong");

  property p_low_button;
    low_btn_s |=> low_key_r;
  endproperty
  a_low_button: assert property (p_low_button) else $error("low button ignored");

  property p_high_button;
    high_btn_s && !(stop_prio && stop_res) |=> high_key_r;
  endproperty
  a_high_button: assert property (p_high_button) else $error("high button ignored");

  property p_checkback;
    (low_cb_s |=> low_key_r) and (high_cb_s && !(stop_prio && stop_res) |=> high_key_r);
  endproperty
  a_checkback: assert property (p_checkback) else $error("checkback key lost");

  property p_voice_req;
    voice_s && !stop_res && !high_req && !low_req |=> voice_key_r;
  endproperty
  a_voice_req: assert property (p_voice_req) else $error("voice request ignored");

  property p_any_key;
    $rose(any_key_r) |-> $past(high_req || low_req || voice_s);
  endproperty
  a_any_key: assert property (p_any_key) else $error("any key without cause");

  // The transmitter only radiates when the any key is up, so it must track
  // every level key exactly, never lag or lead one of them.
  property p_any_follow;
    any_key_r == (high_key_r || low_key_r || voice_key_r);
  endproperty
  a_any_follow: assert property (p_any_follow) else $error("any key differs from keys");

  property p_lamps;
    $rose(voice_lamp_o) |-> $past(voice_s && !stop_res) && !high_level_lamp_o;
  endproperty
  a_lamps: assert property (p_lamps) else $error("voice lamp without voice");

  property p_stop_prio;
    stop_prio && stop_res |=> !high_level_key_o;
  endproperty
  a_stop_prio: assert property (p_stop_prio) else $error("stop did not block high");

  property p_stop_voice;
    stop_res |=> !voice_key_o;
  endproperty
  a_stop_voice: assert property (p_stop_voice) else $error("stop did not block voice");

  property p_voice_block;
    high_key_r || low_key_r |-> !voice_key_r;
  endproperty
  a_voice_block: assert property (p_voice_block) else $error("voice with other key");

  property p_tri_high;
    tristate && term_high_s && !term_low_s |=> high_key_r && !stop_res_r;
  endproperty
  a_tri_high: assert property (p_tri_high) else $error("tri-state high wrong");

  property p_tri_low;
    tristate && term_low_s && !term_high_s && !high_btn_s && !high_cb_s
      |=> !high_key_r && stop_res_r;
  endproperty
  a_tri_low: assert property (p_tri_low) else $error("tri-state low wrong");

  property p_tri_open;
    tristate && !term_low_s && !term_high_s |=> !start_res_r && !stop_res_r;
  endproperty
  a_tri_open: assert property (p_tri_open) else $error("tri-state open wrong");

  property p_start_wins;
    !stop_prio && start_res && stop_res |=> high_key_r;
  endproperty
  a_start_wins: assert property (p_start_wins) else $error("stop beat start");

  c_prio_block: cover property (stop_prio && start_res && stop_res ##1 !high_key_r);
  c_tri_cycle: cover property (tristate && start_res ##[1:20] tristate && stop_res);
  c_voice_on: cover property (voice_key_r ##1 !voice_key_r);
  c_apb_write: cover property (access_ph && pwrite_i && hit_cfg);

endmodule : carrier_keying_logic
`default_nettype wire

// >>> rtl/keying_pkg.sv
// Constants, register map and pin layout of the carrier keying logic.
// Notes on behaviour
// - Normal start sense: applied voltage starts carrier.
// - Inverted start sense: removed voltage starts carrier.
// - Any carrier start keys high level.
// - Stop active per stop sense jumper.
// - Low test active per its sense jumper.
// - Low test button starts low-level test.
// - High test button starts high-level test.
// - Checkback inputs key high or low level.
// - Voice request input keys voice level.
// - Any key follows low, voice or high.
// - Lamps show high, low and voice keying.
// - Stop priority jumper: stop blocks high key.
// - Stop always blocks the voice key.
// - High or low key blocks voice.
// - Tri-state high: start, no stop.
// - Tri-state low: stop, no start.
// - Tri-state open: neither start nor stop.
`default_nettype none
package keying_pkg;

  // ==========================================================================
  // Pin layout of the synchroniser bank
  localparam int unsigned NUM_PINS      = 10;
  localparam int unsigned PIN_START     = 0;
  localparam int unsigned PIN_STOP      = 1;
  localparam int unsigned PIN_LOW_TEST  = 2;
  localparam int unsigned PIN_HIGH_CB   = 3;
  localparam int unsigned PIN_LOW_CB    = 4;
  localparam int unsigned PIN_VOICE     = 5;
  localparam int unsigned PIN_HIGH_BTN  = 6;
  localparam int unsigned PIN_LOW_BTN   = 7;
  localparam int unsigned PIN_TERM_HIGH = 8;
  localparam int unsigned PIN_TERM_LOW  = 9;

  // ==========================================================================
  // Register map
  localparam int unsigned ADDR_W        = 12;
  localparam logic [11:0] CFG_OFFSET    = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // ==========================================================================
  // Jumper register fields
  localparam int unsigned CFG_W            = 5;
  localparam int unsigned CFG_START_INV    = 0;
  localparam int unsigned CFG_STOP_INV     = 1;
  localparam int unsigned CFG_LOW_INV      = 2;
  localparam int unsigned CFG_STOP_PRIO    = 3;
  localparam int unsigned CFG_TRISTATE     = 4;
  localparam logic [4:0]  CFG_RST          = 5'h00;

  // ==========================================================================
  // Status register fields
  localparam int unsigned STAT_PINS_POS    = 0;
  localparam int unsigned STAT_HIGH_KEY    = 16;
  localparam int unsigned STAT_LOW_KEY     = 17;
  localparam int unsigned STAT_VOICE_KEY   = 18;
  localparam int unsigned STAT_ANY_KEY     = 19;
  localparam int unsigned STAT_START       = 20;
  localparam int unsigned STAT_STOP        = 21;
  localparam int unsigned STAT_CFG_POS     = 24;

endpackage : keying_pkg
`default_nettype wire

// >>> rtl/pin_sync.sv
// Two-flip-flop synchroniser bank for the relay lines and buttons.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
  // Clock and reset
  input  wire logic   ref_clk_i,
  input  wire logic   rst_n_i,
  // Pins in, synchronised copies out
  pin_sync_if.sync_mp sif
);

  // ==========================================================================
  // One stage pair per pin
  for (genvar i = 0; i < keying_pkg::NUM_PINS; i++) begin : g_bit
    logic meta_r;
    logic hold_r;
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_r <= 1'b0;
        hold_r <= 1'b0;
      end else begin
        meta_r <= sif.raw[i];
        hold_r <= meta_r;
      end
    end
    assign sif.sync[i] = hold_r;
  end

endmodule : pin_sync
`default_nettype wire

// >>> rtl/pin_sync_if.sv
// Interface between the top module and its pin synchroniser bank.
`timescale 1ns/100ps
`default_nettype none
interface pin_sync_if;
  logic [keying_pkg::NUM_PINS-1:0] raw;
  logic [keying_pkg::NUM_PINS-1:0] sync;
  modport sync_mp (input raw, output sync);
  modport user_mp (output raw, input sync);
endinterface : pin_sync_if
`default_nettype wire

// >>> test/carrier_keying_logic_tb.sv
// Self-checking bench for the carrier keying logic.
`timescale 1ns/100ps
`default_nettype none
module carrier_keying_logic_tb;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} apb_exp_t;
  // ==========================================================================
  // Signals
  logic        ref_clk_i  = 1'b0;
  logic        rst_n_i    = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [3:0]  pstrb      = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  cfg_drv    = 5'h00;
  logic [9:0]  cmd        = 10'h000;
  logic [9:0]  pin;
  logic        high_key;
  logic        voice_key;
  logic        any_key;
  logic        high_lamp;
  logic        low_lamp;
  logic        voice_lamp;
  logic [23:0] lfsr_r     = 24'h01587c;
  int          num_errors = 0;
  int          n_tests    = 0;
  apb_exp_t    rd_q[$];
  logic [5:0]  key_q[$];
  logic [5:0]  key_e;
  apb_exp_t    mon_e;
  event        key_ev;

  always #50 ref_clk_i = ~ref_clk_i;

  // ==========================================================================
  // Design and far side
  carrier_keying_logic dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr),
    .start_line_i(pin[0]), .stop_line_i(pin[1]), .low_level_test_line_i(pin[2]),
    .high_checkback_i(pin[3]), .low_checkback_i(pin[4]), .voice_request_i(pin[5]),
    .relay_terminal_line_high_i(pin[8]), .relay_terminal_line_low_i(pin[9]),
    .high_test_button_i(pin[6]), .low_test_button_i(pin[7]),
    .high_level_key_o(high_key), .voice_key_o(voice_key), .any_key_o(any_key),
    .high_level_lamp_o(high_lamp), .low_level_lamp_o(low_lamp), .voice_lamp_o(voice_lamp)
  );

  relay_contacts u_relay (
    .ref_clk_i(ref_clk_i), .tristate_i(cfg_drv[4]), .cmd_i(cmd), .pins_o(pin)
  );

  // ==========================================================================
  // Helpers
  function automatic logic [23:0] lfsr_next(input logic [23:0] x);
    return {x[22:0], x[23] ^ x[22] ^ x[21] ^ x[16]};
  endfunction : lfsr_next

  // Result bits: stop, start, any, voice, low, high, as in the status word.
  function automatic logic [5:0] exp_keys(input logic [4:0] c, input logic [9:0] p);
    logic st;
    logic sp;
    logic lo;
    logic hi;
    logic vo;
    st = c[4] ? (p[8] & !p[9]) : (p[0] ^ c[0]);
    sp = c[4] ? (p[9] & !p[8]) : (p[1] ^ c[1]);
    lo = (p[2] ^ c[2]) | p[7] | p[4];
    hi = (st | p[6] | p[3]) & !(c[3] & sp);
    vo = p[5] & !sp & !hi & !lo;
    return {sp, st, hi | lo | vo, vo, lo, hi};
  endfunction : exp_keys

  task automatic cmp_bit(input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp_word

  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] e, input logic [31:0] m,
                     input logic er);
    @(posedge ref_clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    rd_q.push_back('{e, m, er});
    @(posedge ref_clk_i);
    penable <= 1'b1;
    do @(posedge ref_clk_i); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic apply(input logic [4:0] c, input logic [9:0] p);
    logic [9:0] q;
    logic [5:0] k;
    q = c[4] ? p : {2'b00, p[7:0]};
    k = exp_keys(c, q);
    apb(1'b1, keying_pkg::CFG_OFFSET, {27'h0, c}, 4'h1, 32'h0, 32'h0, 1'b0);
    cfg_drv <= c;
    cmd     <= p;
    repeat (4) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    key_q.push_back(k);
    -> key_ev;
    apb(1'b0, keying_pkg::STATUS_OFFSET, 32'h0, 4'h0, {3'h0, c, 2'h0, k, 6'h0, q},
        c[4] ? 32'hffff_fffc : 32'hffff_ffff, 1'b0);
  endtask : apply

  // ==========================================================================
  // Monitors
  always @(posedge ref_clk_i) begin
    if (psel && penable && pready === 1'b1) begin
      mon_e = rd_q.pop_front();
      cmp_word(mon_e.data & mon_e.mask, prdata & mon_e.mask);
      cmp_bit(mon_e.err, pslverr);
    end
  end

  always @(key_ev) begin
    key_e = key_q.pop_front();
    cmp_bit(key_e[0], high_key);
    cmp_bit(key_e[2], voice_key);
    cmp_bit(key_e[3], any_key);
    cmp_word({29'h0, key_e[0], key_e[1], key_e[2]}, {29'h0, high_lamp, low_lamp, voice_lamp});
  end

  // ==========================================================================
  // Watchdog and main sequence
  initial begin
    repeat (6000) @(posedge ref_clk_i);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    apb(1'b0, keying_pkg::CFG_OFFSET, 32'h0, 4'h0, 32'h0, 32'hffff_ffff, 1'b0);
    apb(1'b1, keying_pkg::STATUS_OFFSET, 32'hffff_ffff, 4'hf, 32'h0, 32'h0, 1'b0);
    apb(1'b1, keying_pkg::CFG_OFFSET, 32'h0000_001f, 4'he, 32'h0, 32'h0, 1'b0);
    apb(1'b0, keying_pkg::CFG_OFFSET, 32'h0, 4'h0, 32'h0, 32'hffff_ffff, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_001f, 4'hf, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h008, 32'h0, 4'h0, 32'h0, 32'hffff_ffff, 1'b1);
    apb(1'b1, keying_pkg::CFG_OFFSET, 32'hffff_ffff, 4'hf, 32'h0, 32'h0, 1'b0);
    apb(1'b0, keying_pkg::CFG_OFFSET, 32'h0, 4'h0, 32'h0000_001f, 32'hffff_ffff, 1'b0);
    apply(5'h00, 10'h003);
    apply(5'h08, 10'h003);
    apply(5'h08, 10'h024);
    apply(5'h02, 10'h020);
    apply(5'h00, 10'h0a0);
    apply(5'h10, 10'h100);
    apply(5'h18, 10'h240);
    apply(5'h10, 10'h320);
    apply(5'h07, 10'h007);
    for (int i = 0; i < 64; i++) begin
      lfsr_r = lfsr_next(lfsr_r);
      apply(i[4:0], lfsr_r[9:0]);
    end
    end_of_test();
  end
endmodule : carrier_keying_logic_tb
`default_nettype wire

// >>> test/relay_contacts.sv
// Behavioural relay system contacts and front panel buttons facing the keying logic.
`timescale 1ns/100ps
`default_nettype none
module relay_contacts (
  // Clock
  input  wire logic       ref_clk_i,
  // Wiring choice and commanded contact states
  input  wire logic       tristate_i,
  input  wire logic [9:0] cmd_i,
  // Pins towards the keying logic
  output logic      [9:0] pins_o
);
  // ==========================================================================
  // Floating lines
  logic idle_r = 1'b0;

  // The separate start and stop lines are unwired in tri-state wiring, so they
  // wander; a design that wrongly listens to them cannot pass by luck.
  always_ff @(posedge ref_clk_i) begin
    idle_r <= ~idle_r;
  end

  // ==========================================================================
  // Contact wiring
  always_comb begin
    if (tristate_i) begin
      pins_o = {cmd_i[9:8], cmd_i[7:2], idle_r, ~idle_r};
    end else begin
      pins_o = {2'b00, cmd_i[7:0]};
    end
  end
endmodule : relay_contacts
`default_nettype wire
